// file: include/wepc_map.svh
/*
 power wake control register map: offsets, bit positions, reset values
 and timing counts for the wake event block.
 assumes inclusion by bare name from the design files.
*/
`ifndef WEPC_MAP_SVH
`define WEPC_MAP_SVH

// ------------------------------------------------------------
// offsets (byte addresses)
// ------------------------------------------------------------
`define WEPC_OFF_CTRL     12'h084
`define WEPC_OFF_INTERRUPT_STATUS_REGISTER  12'h088
`define WEPC_OFF_INT_MASK 12'h08c

// ------------------------------------------------------------
// power_wake_control bit positions
// ------------------------------------------------------------
`define WEPC_B_PORT2_ENERGY_STATUS   17
`define WEPC_B_PORT1_ENERGY_STATUS   16
`define WEPC_B_PORT2_ENERGY_WAKE_ENABLE    15
`define WEPC_B_PORT1_ENERGY_WAKE_ENABLE    14
`define WEPC_B_VIRTUAL_PHY_RESET  10
`define WEPC_B_LAN_EN    9
`define WEPC_B_LAN_STS   5
`define WEPC_B_IND_MODE  3
`define WEPC_B_PIN_EN    1
`define WEPC_B_READY     0

// read-write bits mask (reserved, write-one-clear status, reset and ready bits drop out)
`define WEPC_CTRL_WMASK  32'h0000_c20a
`define WEPC_CTRL_RESET  32'h0000_0000

// ------------------------------------------------------------
// interrupt status bit positions
// ------------------------------------------------------------
`define WEPC_I_WAKE      0
`define WEPC_I_VPHY_DONE 1
`define WEPC_INT_BITS    2

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define WEPC_CLK_HZ      10000000
`define WEPC_PULSE_MS    50
`define WEPC_PULSE_CYC   ((`WEPC_CLK_HZ / 1000) * `WEPC_PULSE_MS)

`endif

// file: include/wepc_pkg.sv
/*
 types for the wake event power control block.
 assumes nothing beyond a sv compiler.
*/
package wepc_pkg;

   // source events sampled from the phys and host mac
   typedef struct packed
   {
      logic port2_energy;
      logic port1_energy;
      logic lan_wake;
   } wepc_evt_t;

   // pulse generator states
   typedef enum logic [1:0]
   {
      WEPC_IDLE  = 2'b00,
      WEPC_PULSE = 2'b01,
      WEPC_HOLD  = 2'b10
   } wepc_state_t;

endpackage

// file: hw/wepc_pulse.sv
/*
 wake output former: static level or fixed-length pulse per event.
 assumes a single clock and events synchronous to it.
*/
`timescale 1ns/1ns
`include "wepc_map.svh"

module wepc_pulse
#(
   parameter int PULSE_CYC = `WEPC_PULSE_CYC
)
(
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // control
   input  wire logic pulse_mode_i,
   input  wire logic new_event_i,
   input  wire logic active_i,
   // output
   output logic      wake_o
);

   // refuse a pulse length the counter cannot serve
   if (PULSE_CYC < 1)
   begin : g_len_check
      $error("pulse length must be at least one cycle");
   end

   wepc_pkg::wepc_state_t state_q;
   wepc_pkg::wepc_state_t state_d;
   logic [31:0]           cnt_q;
   logic [31:0]           cnt_d;
   logic                  wake_q;
   logic                  wake_d;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         wepc_pkg::WEPC_IDLE:
         begin
            if (new_event_i && pulse_mode_i)
            begin
               state_d = wepc_pkg::WEPC_PULSE;
               cnt_d   = 32'(PULSE_CYC - 1);
            end
            else if (active_i && !pulse_mode_i)
            begin
               state_d = wepc_pkg::WEPC_HOLD;
            end
         end
         wepc_pkg::WEPC_PULSE:
         begin
            if (!active_i)
            begin
               state_d = wepc_pkg::WEPC_IDLE;
            end
            else if (new_event_i)
            begin
               cnt_d = 32'(PULSE_CYC - 1);
            end
            else if (cnt_q == 32'h0000_0000)
            begin
               state_d = wepc_pkg::WEPC_IDLE;
            end
            else
            begin
               cnt_d = cnt_q - 32'h0000_0001;
            end
         end
         wepc_pkg::WEPC_HOLD:
         begin
            if (!active_i || pulse_mode_i)
            begin
               state_d = wepc_pkg::WEPC_IDLE;
            end
         end
         default:
         begin
            state_d = wepc_pkg::WEPC_IDLE;
         end
      endcase
      wake_d = (state_d != wepc_pkg::WEPC_IDLE);
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_q <= wepc_pkg::WEPC_IDLE;
         cnt_q   <= 32'h0000_0000;
         wake_q  <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         wake_q  <= wake_d;
      end
   end

   assign wake_o = wake_q;

endmodule

// file: hw/wepc_virtual_phy_reset.sv
/*
 virtual phy reset sequencer: self-clearing request bit.
 assumes the virtual phy returns a done level when out of reset.
*/
`timescale 1ns/1ns

module wepc_virtual_phy_reset
(
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // control
   input  wire logic req_i,
   input  wire logic vphy_out_of_rst_i,
   // status
   output logic      busy_o,
   output logic      done_o
);

   logic busy_q;
   logic busy_d;
   logic seen_q;
   logic seen_d;
   logic done_q;
   logic done_d;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      busy_d = busy_q;
      seen_d = seen_q;
      done_d = 1'b0;
      if (!busy_q && req_i)
      begin
         busy_d = 1'b1;
         seen_d = 1'b0;
      end
      else if (busy_q && !seen_q)
      begin
         // wait one cycle so reset reaches the virtual phy
         seen_d = 1'b1;
      end
      else if (busy_q && vphy_out_of_rst_i)
      begin
         busy_d = 1'b0;
         done_d = 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         busy_q <= 1'b0;
         seen_q <= 1'b0;
         done_q <= 1'b0;
      end
      else
      begin
         busy_q <= busy_d;
         seen_q <= seen_d;
         done_q <= done_d;
      end
   end

   assign busy_o = busy_q;
   assign done_o = done_q;

endmodule

// file: hw/wepc_top.sv
/*
 wake event power control: power_wake_control register, wake output,
 interrupt status and mask, avalon-mm slave.
 assumes phy and host mac event levels synchronous to core_clk_i.
*/
// Overview of operation
// - port 2 energy event sets bit 17
// - port 1 energy event sets bit 16
// - write-one clear, held while source stands
// - port 2 enable 15 drives wake output
// - port 1 enable 14 drives wake output
// - enabled source sets interrupt regardless pin
// - writing one to bit 10 resets phy
// - reset bit self clears on release
// - writes still taken while reset bit high
// - lan enable 9 drives wake output
// - register readable while not ready
// - bit 3 picks pulse or level
// - bit 1 gates pin, not interrupt
// - clear status or enable ends wake
`timescale 1ns/1ns
`include "wepc_map.svh"

module wepc_top
#(
   parameter int PULSE_CYC = `WEPC_PULSE_CYC
)
(
   // clock and reset
   input  wire logic                  core_clk_i,
   input  wire logic                  rst_i,
   // avalon-mm slave
   input  wire logic [11:0]           avs_address_i,
   input  wire logic                  avs_read_i,
   input  wire logic                  avs_write_i,
   input  wire logic [31:0]           avs_writedata_i,
   input  wire logic [3:0]            avs_byteenable_i,
   output logic      [31:0]           avs_readdata_o,
   output logic                       avs_waitrequest_o,
   output logic      [1:0]            avs_response_o,
   // event sources and device state
   input  wire wepc_pkg::wepc_evt_t   evt_i,
   input  wire logic                  device_ready_i,
   input  wire logic                  vphy_out_of_rst_i,
   // outputs
   output logic                       vphy_reset_o,
   output logic                       wake_event_output_o,
   output logic                       irq_o
);

   // refuse a pulse length the wake former cannot serve
   if (PULSE_CYC < 1)
   begin : g_len_check
      $error("pulse length must be at least one cycle");
   end

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   wepc_pkg::wepc_evt_t        sts_q;
   wepc_pkg::wepc_evt_t        sts_d;
   wepc_pkg::wepc_evt_t        en_q;
   wepc_pkg::wepc_evt_t        en_d;
   wepc_pkg::wepc_evt_t        evt_q;
   logic                       mode_q;
   logic                       mode_d;
   logic                       pin_en_q;
   logic                       pin_en_d;
   logic [`WEPC_INT_BITS-1:0]  isr_q;
   logic [`WEPC_INT_BITS-1:0]  isr_d;
   logic [`WEPC_INT_BITS-1:0]  imask_q;
   logic [`WEPC_INT_BITS-1:0]  imask_d;
   logic [31:0]                rdata_q;
   logic [31:0]                rdata_d;
   logic                       ack_q;
   logic                       ack_d;
   logic [1:0]                 resp_q;
   logic [1:0]                 resp_d;

   logic [31:0] wmask;
   logic [31:0] wd;
   logic        wr_ctrl;
   logic        wr_sts;
   logic        wr_msk;
   logic        vphy_req;
   logic        vphy_busy;
   logic        vphy_done;
   logic        new_evt;
   logic        wake_active;
   logic        wake_raw;
   logic [31:0] ctrl_rd;
   wepc_pkg::wepc_evt_t rise;
   wepc_pkg::wepc_evt_t hit;

   // byte-lane write mask
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_lane
         assign wmask[gi*8 +: 8] = {8{avs_byteenable_i[gi]}};
      end
   endgenerate

   assign wd      = avs_writedata_i & wmask;
   assign wr_ctrl = avs_write_i && !ack_q
                    && avs_address_i == `WEPC_OFF_CTRL;
   assign wr_sts  = avs_write_i && !ack_q
                    && avs_address_i == `WEPC_OFF_INTERRUPT_STATUS_REGISTER;
   assign wr_msk  = avs_write_i && !ack_q
                    && avs_address_i == `WEPC_OFF_INT_MASK;

   // one to bit 10 starts reset
   assign vphy_req = wr_ctrl && wd[`WEPC_B_VIRTUAL_PHY_RESET];

   // rising edges of source events
   assign rise = evt_i & ~evt_q;
   // enabled sources that newly fired
   assign hit  = rise & en_q;

   // ------------------------------------------------------------
   // register next values
   // ------------------------------------------------------------
   always_comb
   begin
      sts_d    = sts_q;
      en_d     = en_q;
      mode_d   = mode_q;
      pin_en_d = pin_en_q;
      isr_d    = isr_q;
      imask_d  = imask_q;
      if (wr_ctrl)
      begin
         en_d.port2_energy = wd[`WEPC_B_PORT2_ENERGY_WAKE_ENABLE];
         en_d.port1_energy = wd[`WEPC_B_PORT1_ENERGY_WAKE_ENABLE];
         en_d.lan_wake     = wd[`WEPC_B_LAN_EN];
         mode_d            = wd[`WEPC_B_IND_MODE];
         pin_en_d          = wd[`WEPC_B_PIN_EN];
         if (wd[`WEPC_B_PORT2_ENERGY_STATUS])
         begin
            sts_d.port2_energy = 1'b0;
         end
         if (wd[`WEPC_B_PORT1_ENERGY_STATUS])
         begin
            sts_d.port1_energy = 1'b0;
         end
         if (wd[`WEPC_B_LAN_STS])
         begin
            sts_d.lan_wake = 1'b0;
         end
      end
      sts_d = sts_d | evt_i;
      if (wr_sts)
      begin
         isr_d = isr_d & ~wd[`WEPC_INT_BITS-1:0];
      end
      if (wr_msk)
      begin
         imask_d = wd[`WEPC_INT_BITS-1:0];
      end
      if (|hit)
      begin
         isr_d[`WEPC_I_WAKE] = 1'b1;
      end
      if (vphy_done)
      begin
         isr_d[`WEPC_I_VPHY_DONE] = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         sts_q    <= '0;
         en_q     <= '0;
         evt_q    <= '0;
         mode_q   <= 1'b0;
         pin_en_q <= 1'b0;
         isr_q    <= '0;
         imask_q  <= '0;
      end
      else
      begin
         sts_q    <= sts_d;
         en_q     <= en_d;
         evt_q    <= evt_i;
         mode_q   <= mode_d;
         pin_en_q <= pin_en_d;
         isr_q    <= isr_d;
         imask_q  <= imask_d;
      end
   end

   // ------------------------------------------------------------
   // wake output
   // ------------------------------------------------------------
   // any enabled source
   assign new_evt     = |hit;
   assign wake_active = |(sts_q & en_q);

   wepc_pulse
   #(
      .PULSE_CYC    (PULSE_CYC)
   )
   u_pulse
   (
      .clk_i        (core_clk_i),
      .rst_i        (rst_i),
      .pulse_mode_i (mode_q),
      .new_event_i  (new_evt),
      .active_i     (wake_active),
      .wake_o       (wake_raw)
   );

   assign wake_event_output_o = wake_raw & pin_en_q;

   // ------------------------------------------------------------
   // virtual phy reset
   // ------------------------------------------------------------
   wepc_virtual_phy_reset u_vphy
   (
      .clk_i             (core_clk_i),
      .rst_i             (rst_i),
      .req_i             (vphy_req),
      .vphy_out_of_rst_i (vphy_out_of_rst_i),
      .busy_o            (vphy_busy),
      .done_o            (vphy_done)
   );

   assign vphy_reset_o = vphy_busy;
   assign irq_o        = |(isr_q & imask_q);

   // ------------------------------------------------------------
   // read path and bus answer
   // ------------------------------------------------------------
   always_comb
   begin
      ctrl_rd = 32'h0000_0000;
      ctrl_rd[`WEPC_B_PORT2_ENERGY_STATUS]  = sts_q.port2_energy;
      ctrl_rd[`WEPC_B_PORT1_ENERGY_STATUS]  = sts_q.port1_energy;
      ctrl_rd[`WEPC_B_PORT2_ENERGY_WAKE_ENABLE]   = en_q.port2_energy;
      ctrl_rd[`WEPC_B_PORT1_ENERGY_WAKE_ENABLE]   = en_q.port1_energy;
      ctrl_rd[`WEPC_B_VIRTUAL_PHY_RESET] = vphy_busy;
      ctrl_rd[`WEPC_B_LAN_EN]   = en_q.lan_wake;
      ctrl_rd[`WEPC_B_LAN_STS]  = sts_q.lan_wake;
      ctrl_rd[`WEPC_B_IND_MODE] = mode_q;
      ctrl_rd[`WEPC_B_PIN_EN]   = pin_en_q;
      ctrl_rd[`WEPC_B_READY]    = device_ready_i;
      rdata_d = rdata_q;
      resp_d  = resp_q;
      ack_d   = 1'b0;
      if ((avs_read_i || avs_write_i) && !ack_q)
      begin
         ack_d  = 1'b1;
         resp_d = 2'b00;
         rdata_d = 32'h0000_0000;
         case (avs_address_i)
            `WEPC_OFF_CTRL:     rdata_d = ctrl_rd;
            `WEPC_OFF_INTERRUPT_STATUS_REGISTER:  rdata_d[`WEPC_INT_BITS-1:0] = isr_q;
            `WEPC_OFF_INT_MASK: rdata_d[`WEPC_INT_BITS-1:0] = imask_q;
            default:            resp_d = 2'b11;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rdata_q <= 32'h0000_0000;
         ack_q   <= 1'b0;
         resp_q  <= 2'b00;
      end
      else
      begin
         rdata_q <= rdata_d;
         ack_q   <= ack_d;
         resp_q  <= resp_d;
      end
   end

   assign avs_readdata_o    = rdata_q;
   assign avs_response_o    = resp_q;
   assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;

endmodule

// file: verification/wepc_top_asserts.sv
/*
 checker for wepc_top: bus handshake, decode, vphy reset, wake source.
 assumes binding to wepc_top, one clock, reset rst_i.
*/
`timescale 1ns/1ns

module wepc_top_asserts
#(
   parameter int PULSE_CYC = 20
)
(
   // clock and reset
   input  wire logic                core_clk_i,
   input  wire logic                rst_i,
   // bus
   input  wire logic [11:0]         avs_address_i,
   input  wire logic                avs_read_i,
   input  wire logic                avs_write_i,
   input  wire logic [31:0]         avs_writedata_i,
   input  wire logic [31:0]         avs_readdata_o,
   input  wire logic                avs_waitrequest_o,
   input  wire logic [1:0]          avs_response_o,
   // device side
   input  wire wepc_pkg::wepc_evt_t evt_i,
   input  wire logic                vphy_out_of_rst_i,
   input  wire logic                vphy_reset_o,
   input  wire logic                wake_event_output_o
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   logic mapped;
   assign mapped = avs_address_i inside {12'h084, 12'h088, 12'h08c};
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_ans;
      avs_read_i && !avs_waitrequest_o;
   endsequence
   sequence s_ctrl_wr;
      avs_write_i && avs_waitrequest_o && avs_address_i == 12'h084;
   endsequence
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   property p_first_wait;
      $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o;
   endproperty
   property p_one_wait;
      (avs_read_i || avs_write_i) && avs_waitrequest_o
         |=> !avs_waitrequest_o;
   endproperty
   property p_idle;
      !(avs_read_i || avs_write_i) |-> !avs_waitrequest_o;
   endproperty
   property p_unmapped;
      s_ans ##0 !mapped |-> avs_response_o == 2'b11
         && avs_readdata_o == 32'h0;
   endproperty
   property p_ctrl_ok;
      s_ans ##0 avs_address_i == 12'h084 |-> avs_response_o == 2'b00;
   endproperty
   property p_ctrl_rsvd;
      s_ans ##0 avs_address_i == 12'h084 |->
         avs_readdata_o[31:18] == 14'h0 && avs_readdata_o[13:11] == 3'h0;
   endproperty
   property p_wake_src;
      $rose(wake_event_output_o) |-> $past(evt_i != 3'b000)
         || $past(evt_i != 3'b000, 2);
   endproperty
   property p_vphy_set;
      s_ctrl_wr ##0 avs_writedata_i[10] && !vphy_reset_o |=> vphy_reset_o;
   endproperty
   property p_vphy_hold;
      vphy_reset_o && !vphy_out_of_rst_i |=> vphy_reset_o;
   endproperty
   property p_vphy_clear;
      vphy_reset_o && vphy_out_of_rst_i |-> ##[1:8] !vphy_reset_o;
   endproperty
   a_first_wait: assert property (p_first_wait)
      else $error("no wait state on new request");
   a_one_wait: assert property (p_one_wait)
      else $error("request not answered after one wait");
   a_idle: assert property (p_idle)
      else $error("waitrequest high while idle");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not refused");
   a_ctrl_ok: assert property (p_ctrl_ok)
      else $error("control read not okay");
   a_ctrl_rsvd: assert property (p_ctrl_rsvd)
      else $error("reserved control bits nonzero");
   a_wake_src: assert property (p_wake_src)
      else $error("wake rose without source event");
   a_vphy_set: assert property (p_vphy_set)
      else $error("vphy reset not entered");
   a_vphy_hold: assert property (p_vphy_hold)
      else $error("vphy reset left early");
   a_vphy_clear: assert property (p_vphy_clear)
      else $error("vphy reset bit not cleared");
endmodule

bind wepc_top wepc_top_asserts #(.PULSE_CYC(PULSE_CYC)) u_chk
(
   .core_clk_i          (core_clk_i),
   .rst_i               (rst_i),
   .avs_address_i       (avs_address_i),
   .avs_read_i          (avs_read_i),
   .avs_write_i         (avs_write_i),
   .avs_writedata_i     (avs_writedata_i),
   .avs_readdata_o      (avs_readdata_o),
   .avs_waitrequest_o   (avs_waitrequest_o),
   .avs_response_o      (avs_response_o),
   .evt_i               (evt_i),
   .vphy_out_of_rst_i   (vphy_out_of_rst_i),
   .vphy_reset_o        (vphy_reset_o),
   .wake_event_output_o (wake_event_output_o)
);

// file: verification/wepc_pmc_model.sv
/*
 power controller model: measures the length of each wake pulse.
 assumes wake active high, synchronous to clk_i.
*/
`timescale 1ns/1ns

module wepc_pmc_model
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wake pin and measure
   input  wire logic        wake_i,
   output logic      [31:0] last_len_o
);
   logic [31:0] run_q;
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         run_q      <= 32'h0;
         last_len_o <= 32'h0;
      end
      else if (wake_i)
         run_q <= run_q + 32'h1;
      else if (run_q != 32'h0)
      begin
         last_len_o <= run_q;
         run_q      <= 32'h0;
      end
   end
endmodule

// file: verification/wepc_top_tb.sv
/*
 testbench for wepc_top: register, wake, interrupt and vphy tests.
 assumes pulse length shortened to PC cycles, byte lanes all on.
*/
`timescale 1ns/1ns

module wepc_top_tb;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   localparam int          PC = 20;
   localparam logic [11:0] CT = 12'h084;
   localparam logic [11:0] IS = 12'h088;
   localparam logic [11:0] IM = 12'h08c;
   logic                core_clk_i  = 1'b0;
   logic                rst_i       = 1'b1;
   logic [11:0]         adr         = 12'h000;
   logic                rd          = 1'b0;
   logic                wr          = 1'b0;
   logic [31:0]         wd          = 32'h0;
   wepc_pkg::wepc_evt_t evt         = 3'b000;
   logic                rdy         = 1'b0;
   logic                oor         = 1'b0;
   logic [31:0]         rdat;
   logic [31:0]         len;
   logic [1:0]          rsp_o;
   logic [1:0]          rsp;
   logic                wt;
   logic                vrst;
   logic                wake;
   logic                irq;
   int                  fails       = 0;
   int                  comparisons = 0;

   always #50 core_clk_i = ~core_clk_i;

   wepc_top #(.PULSE_CYC(PC)) dut
   (
      .core_clk_i          (core_clk_i),
      .rst_i               (rst_i),
      .avs_address_i       (adr),
      .avs_read_i          (rd),
      .avs_write_i         (wr),
      .avs_writedata_i     (wd),
      .avs_byteenable_i    (4'hf),
      .avs_readdata_o      (rdat),
      .avs_waitrequest_o   (wt),
      .avs_response_o      (rsp_o),
      .evt_i               (evt),
      .device_ready_i      (rdy),
      .vphy_out_of_rst_i   (oor),
      .vphy_reset_o        (vrst),
      .wake_event_output_o (wake),
      .irq_o               (irq)
   );

   wepc_pmc_model u_pmc
   (
      .clk_i      (core_clk_i),
      .rst_i      (rst_i),
      .wake_i     (wake),
      .last_len_o (len)
   );

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic conclude();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic bound(input int n);
      if (n >= 50)
      begin
         fails++;
         conclude();
      end
   endtask

   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge core_clk_i);
      adr <= a;
      wd  <= d;
      wr  <= w;
      rd  <= ~w;
      @(negedge core_clk_i);
      while (wt !== 1'b0 && n < 50)
      begin
         n++;
         @(negedge core_clk_i);
      end
      bound(n);
      @(posedge core_clk_i);
      q   = rdat;
      rsp = rsp_o;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task automatic wrt(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, q);
      check(q, e);
   endtask

   task automatic waitv(input logic v, input logic l);
      int n;
      n = 0;
      while ((v ? vrst : wake) !== l && n < 50)
      begin
         n++;
         @(negedge core_clk_i);
      end
      bound(n);
      check({31'h0, v ? vrst : wake}, {31'h0, l});
      @(posedge core_clk_i);
   endtask

   // ------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (10) @(posedge core_clk_i);
      rst_i <= 1'b0;
      rdc(CT, 32'h0);
      rdc(IS, 32'h0);
      rdc(IM, 32'h0);
      rdy <= 1'b1;
      rdc(CT, 32'h1);
      wrt(CT, 32'hfffc_3800);
      rdc(CT, 32'h1);
      rdc(12'h100, 32'h0);
      check({30'h0, rsp}, 32'h3);
      // port 1 level wake
      wrt(CT, 32'h4002);
      evt.port1_energy <= 1'b1;
      waitv(1'b0, 1'b1);
      rdc(CT, 32'h1_4003);
      rdc(IS, 32'h1);
      wrt(CT, 32'h1_4002);
      rdc(CT, 32'h1_4003);
      evt.port1_energy <= 1'b0;
      wrt(CT, 32'h1_4002);
      waitv(1'b0, 1'b0);
      rdc(CT, 32'h4003);
      evt.port1_energy <= 1'b1;
      waitv(1'b0, 1'b1);
      wrt(CT, 32'h0002);
      waitv(1'b0, 1'b0);
      evt.port1_energy <= 1'b0;
      wrt(CT, 32'h1_0002);
      wrt(IS, 32'h3);
      rdc(IS, 32'h0);
      // port 2, pin gated, interrupt masked
      wrt(IM, 32'h1);
      wrt(CT, 32'h8000);
      evt.port2_energy <= 1'b1;
      repeat (4) @(negedge core_clk_i);
      check({31'h0, wake}, 32'h0);
      check({31'h0, irq}, 32'h1);
      wrt(CT, 32'h8002);
      waitv(1'b0, 1'b1);
      rdc(CT, 32'h2_8003);
      wrt(IM, 32'h0);
      check({31'h0, irq}, 32'h0);
      evt.port2_energy <= 1'b0;
      wrt(CT, 32'h2_0000);
      wrt(IS, 32'h3);
      rdc(CT, 32'h1);
      // lan wake in pulse mode
      wrt(CT, 32'h020a);
      evt.lan_wake <= 1'b1;
      waitv(1'b0, 1'b1);
      evt.lan_wake <= 1'b0;
      waitv(1'b0, 1'b0);
      rdc(CT, 32'h022b);
      check(len, 32'(PC));
      wrt(CT, 32'h0020);
      wrt(IS, 32'h3);
      rdc(CT, 32'h1);
      // virtual phy reset
      wrt(CT, 32'h0400);
      check({31'h0, vrst}, 32'h1);
      wrt(CT, 32'h0000);
      rdc(CT, 32'h0401);
      oor <= 1'b1;
      waitv(1'b1, 1'b0);
      rdc(CT, 32'h1);
      rdc(IS, 32'h2);
      conclude();
   end
endmodule
